/* dppwm_engine.sv */
`timescale 1ns/1ps
// Summary of operation
// - Fetch addresses come from a page base; low eight bits start at zero.
// - Pacing clock runs after init at 19.2 kHz times multiplier, drives requests.
// - While the count is nonzero, each falling edge of the request line moves exactly one byte.
// - Multiplier accepts only 2, 4 or 8; others flag an error.
// - Base is a page number; fetch address adds the byte offset, which can carry into the page.
// - Main and overflow lengths are pages; overflow follows the main area.
// - Every write goes to one port address fixed at init.
// - Swap to a second buffer page takes effect whole, between transfers.
// - When the count runs out, channel outputs keep their last state.
// - Byte bits 2..0 pick a channel; bit 7 turns it on or off.
// - No automatic reload; stops at zero; software rewinds count and offset.
module dppwm_engine #(
  parameter int PAGE_W = 16,
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Setup
  input wire logic engine_init,
  input wire logic [PAGE_W-1:0] buffer_base_page,
  input wire logic [LEN_W-1:0] buffer_page_count,
  input wire logic [LEN_W-1:0] overflow_page_count,
  input wire logic [PAGE_W-1:0] target_port_address,
  input wire logic [3:0] rate_multiplier,
  // Buffer swap
  input wire logic swap_request,
  input wire logic [PAGE_W-1:0] next_buffer_page,
  // Counter rewind
  input wire logic rewind_request,
  input wire logic [LEN_W+dppwm_pkg::PAGE_SHIFT:0] rewind_offset,
  input wire logic [LEN_W+dppwm_pkg::PAGE_SHIFT:0] rewind_count,
  // Memory read
  output logic mem_rd_req,
  output logic [PAGE_W+dppwm_pkg::PAGE_SHIFT-1:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  // Port write
  output logic io_wr_strobe,
  output logic [PAGE_W-1:0] io_wr_addr,
  output logic [7:0] io_wr_data,
  // Outputs and status
  output logic [dppwm_pkg::NUM_CHAN-1:0] channel_out,
  output logic pacing_clock_out,
  output logic transfer_request_line,
  output logic engine_active,
  output logic rate_error,
  output logic [LEN_W+dppwm_pkg::PAGE_SHIFT:0] bytes_remaining
);
  import dppwm_pkg::*;

  localparam int CNT_W = LEN_W + PAGE_SHIFT + 1;
  localparam int ADDR_W = PAGE_W + PAGE_SHIFT;

  if (PAGE_W < 1 || PAGE_W > 24 || LEN_W < 1 || LEN_W > 16) begin : g_bad_params
    $error("dppwm_engine: PAGE_W or LEN_W out of range");
  end

  typedef struct packed {
    dppwm_state_t st;
    logic inited;
    logic run;
    logic [PAGE_W-1:0] base;
    logic [PAGE_W-1:0] next_base;
    logic swap_pend;
    logic [CNT_W-1:0] off;
    logic [CNT_W-1:0] cnt;
    logic rw_pend;
    logic [CNT_W-1:0] rw_off;
    logic [CNT_W-1:0] rw_cnt;
    logic [PAGE_W-1:0] port;
    logic [3:0] mult;
    logic rate_err;
    logic req_pend;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] data;
    logic io_stb;
    logic [NUM_CHAN-1:0] chan;
  } dppwm_eng_st_t;

  localparam dppwm_eng_st_t ENG_RESET = '{st: ST_IDLE, mult: MULT_X2, default: '0};

  dppwm_eng_st_t q;
  dppwm_eng_st_t d;
  dppwm_pace_if pace_bus ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] fetch_addr(input logic [PAGE_W-1:0] page,
                                                   input logic [CNT_W-1:0] off);
    return {page, PAGE_LOW_ZERO} + ADDR_W'(off);
  endfunction

  function automatic logic [NUM_CHAN-1:0] apply_edge(input logic [NUM_CHAN-1:0] chan,
                                                     input logic [7:0] edge_byte);
    logic [NUM_CHAN-1:0] r;
    r = chan;
    r[edge_byte[CHAN_SEL_LSB +: CHAN_SEL_W]] = edge_byte[CHAN_ON_BIT];
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] total_bytes(input logic [LEN_W-1:0] main_pages,
                                                   input logic [LEN_W-1:0] ovf_pages);
    return (CNT_W'(main_pages) + CNT_W'(ovf_pages)) << PAGE_SHIFT;
  endfunction

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  always_comb begin
    d = q;
    d.io_stb = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (q.rw_pend) begin
          d.off = q.rw_off;
          d.cnt = q.rw_cnt;
          d.run = (q.rw_cnt != '0);
          d.rw_pend = 1'b0;
        end else if (q.swap_pend) begin
          d.base = q.next_base;
          d.swap_pend = 1'b0;
        end else if (!q.run) begin
          d.req_pend = 1'b0;
        end else if (q.req_pend) begin
          d.req_pend = 1'b0;
          d.rd_req = 1'b1;
          d.rd_addr = fetch_addr(q.base, q.off);
          d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (mem_rd_ack) begin
          d.rd_req = 1'b0;
          d.data = mem_rd_data;
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        d.io_stb = 1'b1;
        d.chan = apply_edge(q.chan, q.data);
        d.off = CNT_W'(q.off + 1'b1);
        d.cnt = CNT_W'(q.cnt - 1'b1);
        d.run = (q.cnt != CNT_W'(1));
        d.st = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
        d.rd_req = 1'b0;
      end
    endcase
    if (engine_init) begin
      d.inited = 1'b1;
      d.base = buffer_base_page;
      d.port = target_port_address;
      d.rate_err = !mult_valid(rate_multiplier);
      if (mult_valid(rate_multiplier)) begin
        d.mult = rate_multiplier;
      end
      d.off = '0;
      d.cnt = total_bytes(buffer_page_count, overflow_page_count);
      d.run = (total_bytes(buffer_page_count, overflow_page_count) != '0);
      d.st = ST_IDLE;
      d.rd_req = 1'b0;
      d.swap_pend = 1'b0;
      d.rw_pend = 1'b0;
      d.req_pend = 1'b0;
    end
    // New events win over clears made above
    if (swap_request) begin
      d.next_base = next_buffer_page;
      d.swap_pend = 1'b1;
    end
    if (rewind_request) begin
      d.rw_off = rewind_offset;
      d.rw_cnt = rewind_count;
      d.rw_pend = 1'b1;
    end
    if (pace_bus.pace_fall) begin
      d.req_pend = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= ENG_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Pacing clock
  // ----------------------------------------
  assign pace_bus.mult = q.mult;
  assign pace_bus.run = q.inited;

  dppwm_pacer u_pacer (
    .clk(clk),
    .reset_n(reset_n),
    .pace(pace_bus.pacer)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mem_rd_req = q.rd_req;
  assign mem_rd_addr = q.rd_addr;
  assign io_wr_strobe = q.io_stb;
  assign io_wr_addr = q.port;
  assign io_wr_data = q.data;
  assign channel_out = q.chan;
  assign pacing_clock_out = pace_bus.pace_lvl;
  assign transfer_request_line = pace_bus.pace_lvl;
  assign engine_active = q.run;
  assign rate_error = q.rate_err;
  assign bytes_remaining = q.cnt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_page_aligned;
    @(posedge clk) disable iff (!reset_n)
      $rose(q.rd_req) |-> q.rd_addr == {q.base, PAGE_LOW_ZERO} + ADDR_W'(q.off);
  endproperty
  a_page_aligned: assert property (p_page_aligned) else $error("fetch address wrong");

  property p_start_after_fall;
    @(posedge clk) disable iff (!reset_n)
      $rose(q.rd_req) |-> $past(q.req_pend) && $past(q.run);
  endproperty
  a_start_after_fall: assert property (p_start_after_fall) else $error("fetch without request");

  property p_one_byte;
    @(posedge clk) disable iff (!reset_n)
      (q.io_stb && !$past(engine_init) && !$past(rewind_request)) |->
        q.cnt == CNT_W'($past(q.cnt) - 1'b1) ##1 !q.io_stb;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("count not one per transfer");

  property p_mult_legal;
    @(posedge clk) disable iff (!reset_n)
      mult_valid(q.mult);
  endproperty
  a_mult_legal: assert property (p_mult_legal) else $error("illegal multiplier in use");

  property p_init_count;
    @(posedge clk) disable iff (!reset_n)
      engine_init |=> q.cnt == total_bytes($past(buffer_page_count), $past(overflow_page_count))
                      && q.off == '0;
  endproperty
  a_init_count: assert property (p_init_count) else $error("init count wrong");

  property p_port_fixed;
    @(posedge clk) disable iff (!reset_n)
      !engine_init |=> $stable(q.port);
  endproperty
  a_port_fixed: assert property (p_port_fixed) else $error("port changed without init");

  property p_swap_between;
    @(posedge clk) disable iff (!reset_n)
      ($changed(q.base) && !$past(engine_init)) |-> $past(q.st) == ST_IDLE && !q.rd_req;
  endproperty
  a_swap_between: assert property (p_swap_between) else $error("base changed mid transfer");

  property p_hold_stopped;
    @(posedge clk) disable iff (!reset_n)
      (!q.run && q.st == ST_IDLE) |=> $stable(channel_out);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("outputs moved while stopped");

  property p_edge_decode;
    @(posedge clk) disable iff (!reset_n)
      q.io_stb |-> channel_out[q.data[CHAN_SEL_LSB +: CHAN_SEL_W]] == q.data[CHAN_ON_BIT];
  endproperty
  a_edge_decode: assert property (p_edge_decode) else $error("channel decode wrong");

  property p_no_reload;
    @(posedge clk) disable iff (!reset_n)
      (q.cnt == '0 && !engine_init && !q.rw_pend) |=> q.cnt == '0 && !q.run;
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("count reloaded by itself");

  c_transfer: cover property (@(posedge clk) disable iff (!reset_n) q.io_stb);
  c_swap: cover property (@(posedge clk) disable iff (!reset_n) q.swap_pend ##1 !q.swap_pend);
  c_stop: cover property (@(posedge clk) disable iff (!reset_n) q.io_stb && !q.run);

endmodule

/* dppwm_mem_model.sv */
`timescale 1ns/1ps
module dppwm_mem_model #(
  parameter int ADDR_W = 24
) (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic mem_rd_req,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_data,
  // Answer delay in cycles
  input wire logic [3:0] latency
);
  logic req_s;
  logic done;
  logic [ADDR_W-1:0] addr_s;
  int cnt;

  initial begin
    mem_rd_ack = 1'b0;
    mem_rd_data = 8'h00;
    done = 1'b0;
    cnt = 0;
  end

  // ----------------------------------------
  // Buffer content: channel a[2:0], level a[3]
  // ----------------------------------------
  always @(posedge clk) begin
    req_s = mem_rd_req;
    addr_s = mem_rd_addr;
    #1;
    if (req_s && !done && cnt >= int'(latency)) begin
      mem_rd_ack = 1'b1;
      mem_rd_data = {addr_s[3], 4'h0, addr_s[2:0]};
      done = 1'b1;
    end else begin
      // Data not valid: keep it moving
      mem_rd_ack = 1'b0;
      mem_rd_data = ~mem_rd_data;
      if (!req_s) begin
        done = 1'b0;
        cnt = 0;
      end else if (!done) begin
        cnt++;
      end
    end
  end
endmodule

/* dppwm_pace_if.sv */
`timescale 1ns/1ps
interface dppwm_pace_if;
  logic [3:0] mult;
  logic run;
  logic pace_lvl;
  logic pace_fall;

  modport engine (output mult, output run, input pace_lvl, input pace_fall);
  modport pacer (input mult, input run, output pace_lvl, output pace_fall);
endinterface

/* dppwm_pacer.sv */
`timescale 1ns/1ps
module dppwm_pacer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pacing link to the engine
  dppwm_pace_if.pacer pace
);
  import dppwm_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic lvl;
    logic fall;
  } dppwm_pacer_st_t;

  localparam dppwm_pacer_st_t PACER_RESET = '{cnt: '0, lvl: 1'b1, fall: 1'b0};

  dppwm_pacer_st_t q;
  dppwm_pacer_st_t d;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // New multiplier only loads at a half-period boundary
  always_comb begin
    d = q;
    d.fall = 1'b0;
    if (!pace.run) begin
      d.cnt = half_reload(pace.mult);
      d.lvl = 1'b1;
    end else if (q.cnt == '0) begin
      d.lvl = ~q.lvl;
      d.fall = q.lvl;
      d.cnt = half_reload(pace.mult);
    end else begin
      d.cnt = DIV_W'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= PACER_RESET;
    end else begin
      q <= d;
    end
  end

  assign pace.pace_lvl = q.lvl;
  assign pace.pace_fall = q.fall;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_half_period;
    @(posedge clk) disable iff (!reset_n)
      (pace.run && q.cnt == '0 && $past(pace.run)) |=>
        (q.lvl != $past(q.lvl)) && (q.cnt == half_reload($past(pace.mult)));
  endproperty
  a_half_period: assert property (p_half_period) else $error("pacer half period wrong");

  property p_fall_pulse;
    @(posedge clk) disable iff (!reset_n)
      q.fall |-> !q.lvl && $past(q.lvl) ##1 !q.fall;
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("fall pulse not on falling edge");

endmodule

/* dppwm_pkg.sv */
package dppwm_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BASE_RATE_HZ = 19_200;
  localparam int DIV_W = 10;

  // ----------------------------------------
  // Rate multiplier codes
  // ----------------------------------------
  localparam logic [3:0] MULT_X2 = 4'h2;
  localparam logic [3:0] MULT_X4 = 4'h4;
  localparam logic [3:0] MULT_X8 = 4'h8;

  // ----------------------------------------
  // Buffer layout and edge byte fields
  // ----------------------------------------
  localparam int PAGE_SHIFT = 8;
  localparam logic [7:0] PAGE_LOW_ZERO = 8'h00;
  localparam int CHAN_SEL_LSB = 0;
  localparam int CHAN_SEL_W = 3;
  localparam int CHAN_ON_BIT = 7;
  localparam int NUM_CHAN = 8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_WRITE = 3'b100
  } dppwm_state_t;

  function automatic logic mult_valid(input logic [3:0] m);
    return (m == MULT_X2) || (m == MULT_X4) || (m == MULT_X8);
  endfunction

  // Reload value for one half period of the pacing clock
  function automatic logic [DIV_W-1:0] half_reload(input logic [3:0] m);
    int h;
    h = CLK_HZ / (2 * BASE_RATE_HZ * int'(mult_valid(m) ? m : MULT_X2));
    return DIV_W'(h - 1);
  endfunction

endpackage

/* test_dma_pattern_pwm_engine.sv */
`timescale 1ns/1ps
module test_dma_pattern_pwm_engine;
  import dppwm_pkg::*;
  typedef struct packed {
    logic [3:0] mult;
    logic [15:0] base;
    logic [7:0] pages;
    logic [7:0] ovf;
    logic [15:0] port;
    logic [3:0] lat;
  } dppwm_row_t;

  logic clk, reset_n, engine_init, swap_request, rewind_request, mem_rd_ack;
  logic mem_rd_req, io_wr_strobe, pacing_clock_out, transfer_request_line;
  logic engine_active, rate_error;
  logic [15:0] buffer_base_page, target_port_address, next_buffer_page, io_wr_addr, port;
  logic [7:0] buffer_page_count, overflow_page_count, mem_rd_data, io_wr_data, channel_out;
  logic [7:0] exp_ch;
  logic [3:0] rate_multiplier, lat;
  logic [16:0] rewind_offset, rewind_count, bytes_remaining, tot;
  logic [23:0] mem_rd_addr;
  dppwm_row_t rows [3];
  int err_count, compares, cyc, last_req, per, r, k, n;

  dppwm_engine dut_u (.clk, .reset_n, .engine_init, .buffer_base_page, .buffer_page_count,
    .overflow_page_count, .target_port_address, .rate_multiplier, .swap_request,
    .next_buffer_page, .rewind_request, .rewind_offset, .rewind_count, .mem_rd_req,
    .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .io_wr_strobe, .io_wr_addr, .io_wr_data,
    .channel_out, .pacing_clock_out, .transfer_request_line, .engine_active, .rate_error,
    .bytes_remaining);

  dppwm_mem_model mem_u (.clk, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data,
    .latency(lat));

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic do_init(input logic [3:0] m, input logic [15:0] b, input logic [7:0] pg,
                         input logic [7:0] ov, input logic [15:0] pt);
    @(posedge clk);
    #1;
    rate_multiplier = m;
    buffer_base_page = b;
    buffer_page_count = pg;
    overflow_page_count = ov;
    target_port_address = pt;
    port = pt;
    engine_init = 1'b1;
    @(posedge clk);
    #1;
    engine_init = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic rw, input logic [16:0] off, input logic [16:0] cnt,
                       input logic sw, input logic [15:0] pg);
    @(posedge clk);
    #1;
    rewind_request = rw;
    rewind_offset = off;
    rewind_count = cnt;
    swap_request = sw;
    next_buffer_page = pg;
    @(posedge clk);
    #1;
    rewind_request = 1'b0;
    swap_request = 1'b0;
  endtask

  task automatic xfer(input logic [15:0] pg, input logic [16:0] off, input logic [16:0] rem,
                      input int per_exp);
    logic [23:0] a;
    int i;
    a = {pg, 8'h00} + {7'h00, off};
    for (i = 0; i < 3000 && mem_rd_req !== 1'b1; i++) step();
    chk("rd_req", mem_rd_req, 1'b1);
    if (per_exp != 0) chk("period", 32'(cyc - last_req), 32'(per_exp));
    last_req = cyc;
    chk("rd_addr", mem_rd_addr, a);
    chk("pace_req", transfer_request_line, pacing_clock_out);
    for (i = 0; i < 40 && io_wr_strobe !== 1'b1; i++) step();
    exp_ch[a[2:0]] = a[3];
    chk("wr_strobe", io_wr_strobe, 1'b1);
    chk("wr_data", io_wr_data, {a[3], 4'h0, a[2:0]});
    chk("wr_addr", io_wr_addr, port);
    chk("channels", channel_out, exp_ch);
    chk("remaining", bytes_remaining, rem);
    step();
    chk("strobe_len", io_wr_strobe, 1'b0);
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(40 * 40000);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {engine_init, swap_request, rewind_request} = 3'h0;
    buffer_base_page = 16'h0000;
    target_port_address = 16'h0000;
    next_buffer_page = 16'h0000;
    buffer_page_count = 8'h00;
    overflow_page_count = 8'h00;
    rate_multiplier = MULT_X2;
    rewind_offset = 17'h00000;
    rewind_count = 17'h00000;
    lat = 4'h0;
    exp_ch = 8'h00;
    {err_count, compares, cyc, last_req} = '0;
    rows[0] = '{MULT_X2, 16'h0012, 8'h01, 8'h00, 16'h00a5, 4'h0};
    rows[1] = '{MULT_X4, 16'h0100, 8'h01, 8'h01, 16'h005a, 4'h3};
    rows[2] = '{MULT_X8, 16'h7ffe, 8'h02, 8'h01, 16'h0c3c, 4'h6};
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    step();
    chk("rst_pace", pacing_clock_out, 1'b1);
    chk("rst_active", engine_active, 1'b0);
    chk("rst_remaining", bytes_remaining, 17'h00000);
    chk("rst_strobe", io_wr_strobe, 1'b0);
    chk("rst_req", mem_rd_req, 1'b0);
    chk("rst_rate_err", rate_error, 1'b0);
    for (r = 0; r < 3; r++) begin
      do_init(rows[r].mult, rows[r].base, rows[r].pages, rows[r].ovf, rows[r].port);
      lat = rows[r].lat;
      per = 2 * (CLK_HZ / (2 * BASE_RATE_HZ * int'(rows[r].mult)));
      tot = ({9'h000, rows[r].pages} + {9'h000, rows[r].ovf}) << 8;
      chk("init_total", bytes_remaining, tot);
      chk("init_active", engine_active, 1'b1);
      chk("init_rate_err", rate_error, 1'b0);
      for (k = 0; k < 3; k++) xfer(rows[r].base, 17'(k), tot - 17'(k) - 17'd1, k == 0 ? 0 : per);
    end
    pulse(1'b1, 17'h000ff, 17'd2, 1'b0, 16'h0000);
    xfer(16'h7ffe, 17'h000ff, 17'd1, per);
    xfer(16'h7ffe, 17'h00100, 17'd0, per);
    step();
    chk("stopped", engine_active, 1'b0);
    n = 0;
    repeat (3 * per) begin
      step();
      if (mem_rd_req === 1'b1) n++;
    end
    chk("no_reload", 32'(n), 32'd0);
    chk("hold_state", channel_out, exp_ch);
    pulse(1'b1, 17'h00010, 17'd8, 1'b1, 16'h0a0b);
    xfer(16'h0a0b, 17'h00010, 17'd7, 0);
    pulse(1'b0, 17'h00000, 17'h00000, 1'b1, 16'h0033);
    xfer(16'h0033, 17'h00011, 17'd6, per);
    lat = 4'h5;
    do_init(4'h3, 16'h0200, 8'h01, 8'h00, 16'h00a5);
    chk("bad_rate", rate_error, 1'b1);
    xfer(16'h0200, 17'h00000, 17'd255, 0);
    xfer(16'h0200, 17'h00001, 17'd254, per);
    report_and_stop();
  end
endmodule
